/* File: design/sfp_flash_dev.sv */
// serial flash device: parameter table read, reset and latch commands, axi4-lite control
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps

module sfp_flash_dev #(
  parameter logic [7:0] OP_PARAM_RD = 8'h5a,
  parameter logic [7:0] OP_WREN     = 8'h06,
  parameter logic [7:0] OP_WRDI     = 8'h04,
  parameter logic [7:0] OP_DP       = 8'hb9,
  parameter logic [7:0] OP_RDP      = 8'hab
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // serial link pins
  input  wire logic                       sclk,
  input  wire logic                       cs_n,
  input  wire logic [3:0]                 io_in,
  output logic      [3:0]                 io_out,
  output logic      [3:0]                 io_oe_n,
  // axi4-lite write
  input  wire logic [sfp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [sfp_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import sfp_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_CMD  = 3'b001,
    ST_ADR  = 3'b010,
    ST_DUM  = 3'b011,
    ST_DAT  = 3'b100,
    ST_SKIP = 3'b101
  } sfp_link_st_t;

  typedef struct packed {
    logic [1:0]        sclk_s;
    logic              sclk_d;
    logic [1:0]        csn_s;
    logic [3:0]        io_s1;
    logic [3:0]        io_s2;
    sfp_link_st_t      st;
    logic [4:0]        cnt;
    logic [7:0]        opc;
    logic [23:0]       addr;
    logic [7:0]        sh;
    logic [3:0]        io_out;
    logic [3:0]        io_oe_n;
    logic              write_enable_latch;
    logic              dpd;
    logic              arm;
    logic [1:0]        lanes;
    logic [4:0]        dummy;
    logic              awrdy;
    logic              wrdy;
    logic              aw_h;
    logic              w_h;
    logic [AXI_AW-1:0] awa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } sfp_state_t;

  sfp_state_t s_r;
  sfp_state_t s_nxt;
  sfp_rom_if  tbl ();

  sfp_table_rom u_rom (
    .clk  (clk),
    .rstn (rstn),
    .tbl  (tbl.rom)
  );

  // bits moved per link clock edge for the selected lane width
  function automatic logic [4:0] lane_step(input logic [1:0] lanes);
    unique case (lanes)
      LANE_2:  lane_step = 5'h02;
      LANE_4:  lane_step = 5'h04;
      default: lane_step = 5'h01;
    endcase
  endfunction : lane_step

  // shift sampled lanes into the low end, msb first
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [1:0] lanes,
                                           input logic [3:0] io);
    unique case (lanes)
      LANE_2:  shift_in = {v[21:0], io[1:0]};
      LANE_4:  shift_in = {v[19:0], io[3:0]};
      default: shift_in = {v[22:0], io[0]};
    endcase
  endfunction : shift_in

  // place the top bits of a byte on the lanes; single data leaves on io[1]
  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [1:0] lanes);
    unique case (lanes)
      LANE_2:  lane_out = {2'b00, b[7:6]};
      LANE_4:  lane_out = b[7:4];
      default: lane_out = {2'b00, b[7], 1'b0};
    endcase
  endfunction : lane_out

  function automatic logic [3:0] lane_oe_n(input logic [1:0] lanes);
    unique case (lanes)
      LANE_2:  lane_oe_n = 4'hc;
      LANE_4:  lane_oe_n = 4'h0;
      default: lane_oe_n = 4'hd;
    endcase
  endfunction : lane_oe_n

  logic              sclk_rise;
  logic              sclk_fall;
  logic [4:0]        step;
  logic [23:0]       shv;
  logic [7:0]        byte_v;
  logic [31:0]       rd_v;
  logic              rd_ok;

  always_comb begin
    s_nxt     = s_r;
    sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_d;
    sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_d;
    step      = lane_step(s_r.lanes);
    shv       = '0;
    byte_v    = '0;
    rd_v      = '0;
    rd_ok     = 1'b0;

    // pins cross into the clock domain through two flops
    s_nxt.sclk_s = {s_r.sclk_s[0], sclk};
    s_nxt.sclk_d = s_r.sclk_s[1];
    s_nxt.csn_s  = {s_r.csn_s[0], cs_n};
    s_nxt.io_s1  = io_in;
    s_nxt.io_s2  = s_r.io_s1;

    // link engine; deselect always ends the frame and frees the lanes
    if (s_r.csn_s[1]) begin
      s_nxt.st      = ST_OFF;
      s_nxt.io_oe_n = '1;
    end else begin
      unique case (s_r.st)
        ST_OFF: begin
          s_nxt.st  = ST_CMD;
          s_nxt.cnt = OPC_BITS;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            shv       = shift_in({16'h0000, s_r.opc}, s_r.lanes, s_r.io_s2);
            s_nxt.opc = shv[7:0];
            s_nxt.cnt = s_r.cnt - step;
            if (s_r.cnt == step) begin
              s_nxt.st  = ST_SKIP;
              s_nxt.arm = 1'b0;
              if (s_r.dpd && shv[7:0] != OP_RDP) begin
                s_nxt.st = ST_SKIP; // asleep: only release is heard
              end else if (shv[7:0] == OP_PARAM_RD) begin
                s_nxt.st  = ST_ADR;
                s_nxt.cnt = ADR_BITS;
              end else if (shv[7:0] == OP_RST_EN) begin
                s_nxt.arm = 1'b1;
              end else if (shv[7:0] == OP_RST && s_r.arm) begin
                s_nxt.write_enable_latch = 1'b0;
                s_nxt.dpd = 1'b0;
              end else if (shv[7:0] == OP_WREN) begin
                s_nxt.write_enable_latch = 1'b1;
              end else if (shv[7:0] == OP_WRDI) begin
                s_nxt.write_enable_latch = 1'b0;
              end else if (shv[7:0] == OP_DP) begin
                s_nxt.dpd = 1'b1;
              end else if (shv[7:0] == OP_RDP) begin
                s_nxt.dpd = 1'b0;
              end
            end
          end
        end
        ST_ADR: begin
          if (sclk_rise) begin
            s_nxt.addr = shift_in(s_r.addr, s_r.lanes, s_r.io_s2);
            s_nxt.cnt  = s_r.cnt - step;
            if (s_r.cnt == step) begin
              // mode bits, if a host sends any, are absorbed by the dummy count
              if (s_r.dummy == '0) begin
                s_nxt.st  = ST_DAT;
                s_nxt.cnt = '0;
              end else begin
                s_nxt.st  = ST_DUM;
                s_nxt.cnt = s_r.dummy;
              end
            end
          end
        end
        ST_DUM: begin
          if (sclk_rise) begin
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (s_r.cnt == 5'h01) begin
              s_nxt.st = ST_DAT;
            end
          end
        end
        ST_DAT: begin
          if (sclk_fall) begin
            s_nxt.io_oe_n = lane_oe_n(s_r.lanes);
            if (s_r.cnt == '0) begin
              byte_v     = tbl.q;
              s_nxt.addr = s_r.addr + 24'h000001;
              s_nxt.cnt  = BYTE_BITS - step;
            end else begin
              byte_v    = s_r.sh;
              s_nxt.cnt = s_r.cnt - step;
            end
            s_nxt.io_out = lane_out(byte_v, s_r.lanes);
            s_nxt.sh     = byte_v << step;
          end
        end
        ST_SKIP: begin
          s_nxt.st = ST_SKIP;
        end
        default: begin
          s_nxt.st = ST_SKIP;
        end
      endcase
    end

    // axi4-lite write: address and data taken in either order
    if (s_r.awrdy && s_axi_awvalid) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.awa  = s_axi_awaddr;
    end
    if (s_r.wrdy && s_axi_wvalid) begin
      s_nxt.w_h = 1'b1;
      s_nxt.wd  = s_axi_wdata;
      s_nxt.ws  = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
      s_nxt.aw_h   = 1'b0;
      s_nxt.w_h    = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      if (s_r.awa == REG_CTRL) begin
        // a combination with unequal lanes does not exist; that code is ignored
        if (s_r.ws[0] && s_r.wd[CTRL_LANE_LSB +: 2] != LANE_BAD) begin
          s_nxt.lanes = s_r.wd[CTRL_LANE_LSB +: 2];
        end
        if (s_r.ws[1]) begin
          s_nxt.dummy = s_r.wd[CTRL_DUM_LSB +: 5];
        end
      end else if (s_r.awa != REG_STATUS) begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    s_nxt.awrdy = ~s_nxt.aw_h & ~s_nxt.bvalid;
    s_nxt.wrdy  = ~s_nxt.w_h & ~s_nxt.bvalid;

    // axi4-lite read
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arrdy && s_axi_arvalid) begin
      if (s_axi_araddr == REG_CTRL) begin
        rd_ok                         = 1'b1;
        rd_v[CTRL_LANE_LSB +: 2]      = s_r.lanes;
        rd_v[CTRL_DUM_LSB +: 5]       = s_r.dummy;
      end else if (s_axi_araddr == REG_STATUS) begin
        rd_ok                         = 1'b1;
        rd_v[STS_WEL]                 = s_r.write_enable_latch;
        rd_v[STS_DPD]                 = s_r.dpd;
        rd_v[STS_SEL]                 = ~s_r.csn_s[1];
        rd_v[STS_ARM]                 = s_r.arm;
        rd_v[STS_OPC_LSB +: 8]        = s_r.opc;
      end
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_v;
      s_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arrdy = ~s_nxt.rvalid;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r         <= '0;
      s_r.csn_s   <= 2'b11;
      s_r.io_oe_n <= 4'hf;
      s_r.st      <= ST_OFF;
      s_r.write_enable_latch     <= 1'b0;
      s_r.dpd     <= 1'b0;
      s_r.lanes   <= LANE_1;
      s_r.dummy   <= DUMMY_RST;
      s_r.awrdy   <= 1'b1;
      s_r.wrdy    <= 1'b1;
      s_r.arrdy   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // the table address is held in a flop; its byte is ready long before the next link edge
  assign tbl.addr      = s_r.addr;
  assign io_out        = s_r.io_out;
  assign io_oe_n       = s_r.io_oe_n;
  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready  = s_r.wrdy;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
endmodule : sfp_flash_dev

/* File: design/sfp_pkg.sv */
// constants shared by the parameter-table flash device and its table memory
package sfp_pkg;
  // register bus
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // control fields
  localparam int          CTRL_LANE_LSB = 0;
  localparam int          CTRL_DUM_LSB  = 8;
  localparam logic [4:0]  DUMMY_RST     = 5'h08;
  // status fields
  localparam int          STS_WEL       = 0;
  localparam int          STS_DPD       = 1;
  localparam int          STS_SEL       = 2;
  localparam int          STS_ARM       = 3;
  localparam int          STS_OPC_LSB   = 8;
  // lane modes: opcode, address and data all use the same width
  localparam logic [1:0]  LANE_1        = 2'h0;
  localparam logic [1:0]  LANE_2        = 2'h1;
  localparam logic [1:0]  LANE_4        = 2'h2;
  localparam logic [1:0]  LANE_BAD      = 2'h3;
  // opcodes
  localparam logic [7:0]  OP_RST_EN     = 8'h66;
  localparam logic [7:0]  OP_RST        = 8'h99;
  localparam logic [7:0]  OP_LOCK       = 8'h36;
  // link framing
  localparam logic [4:0]  OPC_BITS      = 5'h08;
  localparam logic [4:0]  ADR_BITS      = 5'h18;
  localparam logic [4:0]  BYTE_BITS     = 5'h08;
  // parameter table
  localparam logic [19:0] TBL_PAGE      = 20'h00006;
  localparam logic [7:0]  TBL_BLANK     = 8'hff;
  localparam logic [7:0]  VMAX_LO       = 8'h00;
  localparam logic [7:0]  VMAX_HI       = 8'h36;
  localparam logic [7:0]  VMIN_LO       = 8'h00;
  localparam logic [7:0]  VMIN_HI       = 8'h27;
  // feature word 64h-65h
  localparam logic        F_HWRST       = 1'b0;
  localparam logic        F_PAUSE       = 1'b1;
  localparam logic        F_DPD         = 1'b1;
  localparam logic        F_SWRST       = 1'b1;
  localparam logic        F_PGM_SUSP    = 1'b0;
  localparam logic        F_ERS_SUSP    = 1'b0;
  localparam logic        F_WRAP        = 1'b0;
  localparam logic [15:0] FEAT_WORD     = {F_WRAP, 1'b1, F_ERS_SUSP, F_PGM_SUSP, OP_RST,
                                           F_SWRST, F_DPD, F_PAUSE, F_HWRST};
  // lock word 68h-69h
  localparam logic        L_BLOCK       = 1'b1;
  localparam logic        L_NONVOL      = 1'b0;
  localparam logic        L_DFLT_UNPROT = 1'b0;
  localparam logic        L_OTP         = 1'b1;
  localparam logic        L_RDLOCK      = 1'b1;
  localparam logic        L_PERM        = 1'b1;
  localparam logic [15:0] LOCK_WORD     = {2'b11, L_PERM, L_RDLOCK, L_OTP, L_DFLT_UNPROT,
                                           OP_LOCK, L_NONVOL, L_BLOCK};
endpackage : sfp_pkg

/* File: design/sfp_rom_if.sv */
// link between the serial engine and the parameter table memory
`timescale 1ns/100ps
interface sfp_rom_if;
  logic [23:0] addr;
  logic [7:0]  q;
  modport ctl (output addr, input q);
  modport rom (input addr, output q);
endinterface : sfp_rom_if

/* File: design/sfp_table_rom.sv */
// parameter table memory, registered read data
`timescale 1ns/100ps
module sfp_table_rom (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // table port
  sfp_rom_if.rom   tbl
);
  import sfp_pkg::*;

  typedef struct packed {
    logic [7:0] q;
  } sfp_rom_state_t;

  sfp_rom_state_t s_r;
  sfp_rom_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.q = TBL_BLANK;
    if (tbl.addr[23:4] == TBL_PAGE) begin
      unique case (tbl.addr[3:0])
        4'h0:    s_nxt.q = VMAX_LO;
        4'h1:    s_nxt.q = VMAX_HI;
        4'h2:    s_nxt.q = VMIN_LO;
        4'h3:    s_nxt.q = VMIN_HI;
        4'h4:    s_nxt.q = FEAT_WORD[7:0];
        4'h5:    s_nxt.q = FEAT_WORD[15:8];
        4'h8:    s_nxt.q = LOCK_WORD[7:0];
        4'h9:    s_nxt.q = LOCK_WORD[15:8];
        default: s_nxt.q = TBL_BLANK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tbl.q = s_r.q;
endmodule : sfp_table_rom

/* File: test/sfp_flash_dev_assertions.sv */
// concurrent checks on the flash device pins and register bus
`timescale 1ns/100ps
module sfp_flash_dev_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // serial link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  // register bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RST_STANDBY: assert property (
    $rose(rstn) |-> io_oe_n == 4'hf && !s_axi_bvalid && !s_axi_rvalid)
    else $error("pins driven or bus busy right after reset");
  AST_OE_CODES: assert property (
    io_oe_n inside {4'hd, 4'hc, 4'h0, 4'hf})
    else $error("output enables form no equal-lane pattern");
  AST_OE_DESEL: assert property (
    cs_n [*6] |-> io_oe_n == 4'hf)
    else $error("lanes still driven while deselected");
  AST_OUT_STEADY: assert property (
    (!cs_n && sclk) [*2] |-> $stable(io_out))
    else $error("data changed while link clock high");
  AST_B_LATENCY: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  AST_R_LATENCY: assert property (
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid)
    else $error("read data late");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed after data");
  AST_R_UNMAPPED: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h04
    |-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  cover property (io_oe_n == 4'h0);
  cover property (io_oe_n == 4'hc);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : sfp_flash_dev_chk

/* File: test/sfp_host_model.sv */
// host controller model: drives the link and collects read bytes
`timescale 1ns/100ps
module sfp_host_model (
  // clock
  input  wire logic       clk,
  // link pins
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n
);
  import sfp_pkg::*;
  logic [3:0] hval;
  logic [3:0] hen;
  logic [7:0] rd_q[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hval = 4'h0;
    hen  = 4'h0;
  end
  // a released lane shows the inverse of its last value so stale data never matches
  always_comb for (int i = 0; i < 4; i++) io_in[i] = !io_oe_n[i] ? io_out[i] :
                                                     (hen[i] ? hval[i] : ~hval[i]);
  // one link clock: 4 clk low then 4 clk high, sampled at the rise
  task automatic unit(input logic [3:0] v, input logic [3:0] en, output logic [3:0] s);
    hval <= v;
    hen  <= en;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    s = io_in;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
  endtask : unit
  task automatic frame(input logic [1:0] ln, input logic [7:0] op, input logic [23:0] adr,
                       input int nadr, input int ndum, input int nbytes);
    int          w;
    logic [3:0]  m;
    logic [3:0]  s;
    logic [31:0] sh;
    logic [7:0]  b;
    w  = (ln == LANE_4) ? 4 : (ln == LANE_2) ? 2 : 1;
    m  = (ln == LANE_4) ? 4'hf : (ln == LANE_2) ? 4'h3 : 4'h1;
    sh = {op, adr};
    b  = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8 + nadr; i += w) begin
      unit(sh[31:28] >> (4 - w), m, s);
      sh = sh << w;
    end
    // mode bits are folded into the dummy clocks, so the host lets go here
    repeat (ndum) unit(hval, 4'h0, s);
    for (int n = 0; n < nbytes; n++) begin
      for (int k = 0; k < 8; k += w) begin
        unit(hval, 4'h0, s);
        b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
      end
      rd_q.push_back(b);
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    hen  <= 4'h0;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : sfp_host_model

/* File: test/testbench.sv */
// self-checking bench for the parameter-table flash device
`timescale 1ns/100ps
bind sfp_flash_dev sfp_flash_dev_chk u_chk (
  .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .io_out(io_out), .io_oe_n(io_oe_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
module testbench;
  import sfp_pkg::*;
  localparam logic [7:0] OPRD  = 8'h5a;
  localparam logic [7:0] OPWE  = 8'h06;
  localparam logic [7:0] OPWD  = 8'h04;
  localparam logic [7:0] OPDP  = 8'hb9;
  localparam logic [7:0] OPRDP = 8'hab;
  localparam int         LIMIT = 20000;
  typedef struct {logic [1:0] ln; logic [4:0] dum; logic [23:0] adr; logic [31:0] exp;} sfp_row_t;
  logic        clk, rstn, sclk, cs_n;
  logic [3:0]  io_in, io_out, io_oe_n, wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          err_total, cmp_count, cyc;
  sfp_row_t    rows [5];
  sfp_flash_dev #(.OP_PARAM_RD(OPRD), .OP_WREN(OPWE), .OP_WRDI(OPWD), .OP_DP(OPDP),
                  .OP_RDP(OPRDP)) u_dut (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sfp_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
                         .io_oe_n(io_oe_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once its own ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {err_total, cmp_count, cyc} = '0;
    rows = '{'{LANE_1, 5'h08, 24'h000060, 32'h00360027},
             '{LANE_2, 5'h04, 24'h000064, 32'h9e49ffff},
             '{LANE_4, 5'h00, 24'h000068, 32'hd9f8ffff},
             '{LANE_1, 5'h01, 24'h00006c, 32'hffffffff},
             '{LANE_4, 5'h08, 24'h00005e, 32'hffff0036}};
    repeat (20) @(posedge clk);
    chk({28'h0, io_oe_n}, 32'h0000000f);
    rstn <= 1'b1;
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000003, 32'h00000000);
    axi_rd(REG_CTRL, v, RESP_OKAY);
    chk(v, {19'h0, DUMMY_RST, 8'h00});
    foreach (rows[r]) begin
      axi_wr(REG_CTRL, {19'h0, rows[r].dum, 6'h00, rows[r].ln}, RESP_OKAY);
      u_host.frame(rows[r].ln, OPRD, rows[r].adr, 24, rows[r].dum, 4);
      for (int k = 0; k < 4; k++) chk({24'h0, u_host.rd_q.pop_front()},
                                      {24'h0, rows[r].exp[31-8*k -: 8]});
    end
    // a lane code with unequal phases must leave the last good setting in place
    axi_wr(REG_CTRL, 32'h00000800, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h00000803, RESP_OKAY);
    axi_rd(REG_CTRL, v, RESP_OKAY);
    chk(v, 32'h00000800);
    axi_wr(8'h10, 32'h00000001, RESP_SLVERR);
    axi_rd(8'h10, v, RESP_SLVERR);
    chk(v, 32'h00000000);
    u_host.frame(LANE_1, OPWE, 24'h0, 0, 0, 0);
    u_host.frame(LANE_1, OP_RST, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000009, 32'h00000001);
    u_host.frame(LANE_1, OP_RST_EN, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000009, 32'h00000009);
    u_host.frame(LANE_1, OP_RST, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000009, 32'h00000000);
    u_host.frame(LANE_1, OPDP, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000002, 32'h00000002);
    u_host.frame(LANE_1, OPWE, 24'h0, 0, 0, 0);
    u_host.frame(LANE_1, OPRDP, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000003, 32'h00000000);
    u_host.frame(LANE_1, OPWE, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000001, 32'h00000001);
    // the latch must also drop on the explicit disable command
    u_host.frame(LANE_1, OPWD, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000001, 32'h00000000);
    u_host.frame(LANE_1, OPWE, 24'h0, 0, 0, 0);
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000001, 32'h00000001);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    axi_rd(REG_STATUS, v, RESP_OKAY);
    chk(v & 32'h00000003, 32'h00000000);
    stop_test();
  end
endmodule : testbench
